// File: core/eep_pkg.sv
// ****************************************************************
// Shared constants for the encoder position emulation
// ****************************************************************
package eep_pkg;

   // Register indices (word addresses on the plain port)
   localparam logic [3:0] EEP_REG_FUNC    = 4'h0; // Output function
   localparam logic [3:0] EEP_REG_PPT     = 4'h1; // Pulses per turn
   localparam logic [3:0] EEP_REG_OFFS    = 4'h2; // Index angle offset
   localparam logic [3:0] EEP_REG_SERCFG  = 4'h3; // Serial word config
   localparam logic [3:0] EEP_REG_STATUS  = 4'h4; // Live status
   localparam logic [3:0] EEP_REG_CLKDIV  = 4'h5; // Serial rate setting

   // Output function codes
   localparam logic [3:0] EEP_FUNC_OFF    = 4'h0; // Outputs idle
   localparam logic [3:0] EEP_FUNC_INCR   = 4'h9; // Quadrature output
   localparam logic [3:0] EEP_FUNC_SERIAL = 4'hA; // Serial absolute

   // Resolution limits in pulses per turn
   localparam logic [19:0] EEP_PPT_RES_MIN  = 20'h00020; // Resolver
   localparam logic [19:0] EEP_PPT_RES_MAX  = 20'h01000;
   localparam logic [19:0] EEP_PPT_ENC_MIN  = 20'h00100; // Encoder
   localparam logic [19:0] EEP_PPT_ENC_MAX  = 20'h80000;
   localparam logic [19:0] EEP_PPT_SAFE_MAX = 20'h01000; // Safety
   localparam logic [19:0] EEP_PPT_RESET    = 20'h00400;

   // Serial word layout
   localparam int EEP_WORD_MAX    = 32; // Longest word in bits
   localparam int EEP_TURN_BITS   = 16; // Position-in-turn field
   localparam logic [4:0] EEP_REVW_MIN   = 5'h0C; // 12 bits
   localparam logic [4:0] EEP_REVW_MAX   = 5'h10; // 16 bits
   localparam logic [4:0] EEP_REVW_RESET = 5'h0C;

   // Serial rate: clock idle time that closes a frame
   localparam int   EEP_CLK_MHZ       = 10;
   localparam int   EEP_MONO_US       = 20; // Frame end timeout
   localparam int   EEP_MONO_CYC      = EEP_MONO_US * EEP_CLK_MHZ;
   localparam logic [15:0] EEP_CLKDIV_RESET = 16'h0008;

   // Status bit positions
   localparam int EEP_ST_BUSY = 0; // Serial frame in progress
   localparam int EEP_ST_PERR = 1; // Rejected resolution
   localparam int EEP_ST_RERR = 2; // Serial clock off rate

endpackage

// File: core/eep_sync.sv
`timescale 1ns/1ps
// ****************************************************************
// Two flip-flop level synchroniser, one per bit
// ****************************************************************
module eep_sync #(
   parameter int W = 1
) (
   input  wire logic         mclk_i,
   input  wire logic         resetn_i,
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);
   logic [W-1:0] stage1; // Read only by stage two

   // First stage catches the level, second settles it
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         stage1 <= '0;
         sync_o <= '0;
      end else begin
         stage1 <= async_i;
         sync_o <= stage1;
      end
   end
endmodule

// File: core/eep_top.sv
`timescale 1ns/1ps
// ****************************************************************
// Encoder position emulation: quadrature or serial absolute output
// ****************************************************************
module eep_top
   import eep_pkg::*;
#(
   parameter int PW = 20 // Position-in-turn input width
) (
   input  wire logic          mclk_i,
   input  wire logic          resetn_i,
   input  wire logic [3:0]    reg_addr_i,
   input  wire logic [31:0]   reg_wdata_i,
   input  wire logic          reg_wr_i,
   input  wire logic          reg_rd_i,
   output logic      [31:0]   reg_rdata_o,
   input  wire logic [PW-1:0] shaft_angle_i,
   input  wire logic [15:0]   shaft_turns_i,
   input  wire logic          feedback_source_type_i,
   input  wire logic          safety_fitted_i,
   input  wire logic          ser_clk_i,
   output logic              ser_data_o,
   output logic              ser_data_oe_o,
   output logic              quad_a_o,
   output logic              quad_b_o,
   output logic              index_pulse_o
);

   // ****************************************************************
   // Registers
   // ****************************************************************
   logic [3:0]  emulation_function_select; // Written function
   logic [19:0] pulses_per_turn_setting;   // Written resolution
   logic [PW-1:0] index_pulse_angle_offset; // Index angle
   logic [4:0]  revolution_field_width;     // Written rev width
   logic        gray_sel;                   // 1 = Gray coding
   logic        dir_invert;                 // 1 = reverse count
   logic [15:0] ser_rate_div;               // Expected half period
   logic        ppt_err;                    // Sticky bad resolution
   logic        rate_err;                   // Sticky off-rate clock
   // Active copies, only updated at safe points
   logic [3:0]  act_func;
   logic [19:0] act_ppt;
   logic [4:0]  act_revw;
   logic        act_gray;
   logic        ser_busy;
   logic        quad_boundary;              // Whole pulse period done
   logic        ppt_ok;

   // Resolution check against feedback and safety option
   always_comb begin
      ppt_ok = 1'b1;
      if (!feedback_source_type_i) begin
         if (reg_wdata_i[19:0] < EEP_PPT_RES_MIN ||
             reg_wdata_i[19:0] > EEP_PPT_RES_MAX)
            ppt_ok = 1'b0;
      end else begin
         if (reg_wdata_i[19:0] < EEP_PPT_ENC_MIN ||
             reg_wdata_i[19:0] > EEP_PPT_ENC_MAX)
            ppt_ok = 1'b0;
      end
      // Only powers of two are binary resolutions
      if (safety_fitted_i && (reg_wdata_i[19:0] > EEP_PPT_SAFE_MAX ||
          (reg_wdata_i[19:0] & (reg_wdata_i[19:0] - 20'h1)) != 20'h0))
         ppt_ok = 1'b0;
   end

   // Software-written settings; a rejected resolution is not stored
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         emulation_function_select <= EEP_FUNC_OFF;
         pulses_per_turn_setting   <= EEP_PPT_RESET;
         index_pulse_angle_offset  <= '0;
         revolution_field_width    <= EEP_REVW_RESET;
         gray_sel                  <= 1'b0;
         dir_invert                <= 1'b0;
         ser_rate_div              <= EEP_CLKDIV_RESET;
      end else if (reg_wr_i) begin
         case (reg_addr_i)
            EEP_REG_FUNC:   emulation_function_select <= reg_wdata_i[3:0];
            EEP_REG_PPT: begin
               if (ppt_ok)
                  pulses_per_turn_setting <= reg_wdata_i[19:0];
            end
            EEP_REG_OFFS:
               index_pulse_angle_offset <= reg_wdata_i[PW-1:0];
            EEP_REG_SERCFG: begin
               // Width clamps into 12..16
               if (reg_wdata_i[4:0] < EEP_REVW_MIN)
                  revolution_field_width <= EEP_REVW_MIN;
               else if (reg_wdata_i[4:0] > EEP_REVW_MAX)
                  revolution_field_width <= EEP_REVW_MAX;
               else
                  revolution_field_width <= reg_wdata_i[4:0];
               gray_sel   <= reg_wdata_i[8];
               dir_invert <= reg_wdata_i[9];
            end
            EEP_REG_CLKDIV: ser_rate_div <= reg_wdata_i[15:0];
            default: ;
         endcase
      end
   end

   // Adopt new settings only when no frame or pulse is open
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         act_func <= EEP_FUNC_OFF;
         act_ppt  <= EEP_PPT_RESET;
         act_revw <= EEP_REVW_RESET;
         act_gray <= 1'b0;
      end else if (!ser_busy && quad_boundary) begin
         act_func <= emulation_function_select;
         act_ppt  <= pulses_per_turn_setting;
         act_revw <= revolution_field_width;
         act_gray <= gray_sel;
      end
   end

   // ****************************************************************
   // Shaft position, direction and index reference
   // ****************************************************************
   logic [PW-1:0] ang_rel; // Angle from index offset, count direction
   logic [PW-1:0] ang_raw;
   assign ang_raw = dir_invert ? PW'(~shaft_angle_i) : shaft_angle_i;
   assign ang_rel = PW'(ang_raw - index_pulse_angle_offset);

   // ****************************************************************
   // Quadrature output: edge index = angle * 4 * ppt / 2^PW
   // ****************************************************************
   logic [PW+21:0] edge_prod;
   logic [21:0]    edge_tgt;  // Target edge count within a turn
   logic [21:0]    edge_cnt;  // Emitted edge count
   logic [21:0]    edge_top;  // Edges per turn
   logic [21:0]    edge_dist; // Forward distance to target, modulo a turn
   assign edge_prod = ang_rel * {act_ppt, 2'b00};
   assign edge_tgt  = edge_prod[PW+21:PW];
   assign edge_top  = {act_ppt, 2'b00};
   assign quad_boundary = (edge_cnt[1:0] == 2'b00);
   // Distance taken modulo the turn, so a wrap past zero steps forward
   assign edge_dist = (edge_tgt >= edge_cnt) ? 22'(edge_tgt - edge_cnt) :
                      22'(edge_tgt + edge_top - edge_cnt);

   // Step one edge per clock toward the target, shortest way round
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         edge_cnt <= '0;
      end else if (act_func != EEP_FUNC_INCR) begin
         edge_cnt <= '0;
      end else if (edge_cnt != edge_tgt) begin
         if (edge_dist < {1'b0, edge_top[21:1]})
            edge_cnt <= (edge_cnt == 22'(edge_top - 22'h1)) ?
                        22'h0 : 22'(edge_cnt + 22'h1);
         else
            edge_cnt <= (edge_cnt == 22'h0) ?
                        22'(edge_top - 22'h1) : 22'(edge_cnt - 22'h1);
      end
   end

   // Gray sequence 00,10,11,01 puts A a quarter period ahead of B
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         quad_a_o      <= 1'b0;
         quad_b_o      <= 1'b0;
         index_pulse_o <= 1'b0;
      end else begin
         quad_a_o <= (act_func == EEP_FUNC_INCR) &
                     (edge_cnt[1] ^ edge_cnt[0]);
         quad_b_o <= (act_func == EEP_FUNC_INCR) & edge_cnt[1];
         // Index only in the A=B=1 quarter of the first period
         index_pulse_o <= (act_func == EEP_FUNC_INCR) &
                          (edge_cnt == 22'h2);
      end
   end

   // ****************************************************************
   // Serial absolute output
   // ****************************************************************
   logic       clk_s;       // Synchronised evaluator clock
   logic       clk_s_n;     // Inverted sample, so reset reads as idle high
   logic       clk_d;       // Previous sample for edge finding
   logic       clk_fall;
   logic       clk_rise;
   logic [31:0] shift_reg;  // Word being sent
   logic [5:0]  bits_left;
   logic [15:0] idle_cnt;   // Cycles since last clock edge
   logic [15:0] half_cnt;   // Cycles in current clock half
   logic [31:0] word_bin;
   logic [31:0] word_out;

   eep_sync #(.W(1)) u_clk_sync (
      .mclk_i   (mclk_i),
      .resetn_i (resetn_i),
      .async_i  (~ser_clk_i),
      .sync_o   (clk_s_n)
   );
   // Synchroniser resets low; inverting keeps reset at the idle level
   assign clk_s = ~clk_s_n;

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i)
         clk_d <= 1'b1;
      else
         clk_d <= clk_s;
   end
   assign clk_fall = clk_d & ~clk_s;
   assign clk_rise = ~clk_d & clk_s;

   // Turns left-aligned in the word, then 16-bit turn field
   always_comb begin
      word_bin = ({16'h0, shaft_turns_i} << EEP_TURN_BITS) |
                 {16'h0, ang_rel[PW-1 -: EEP_TURN_BITS]};
      word_bin = word_bin << (5'h10 - act_revw);
      word_out = act_gray ? (word_bin ^ (word_bin >> 1)) : word_bin;
   end

   // First falling edge latches, rising edges advance MSB first
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         shift_reg     <= '0;
         bits_left     <= '0;
         ser_busy      <= 1'b0;
         ser_data_o    <= 1'b1;
         ser_data_oe_o <= 1'b0;
         idle_cnt      <= '0;
      end else if (act_func != EEP_FUNC_SERIAL) begin
         ser_busy      <= 1'b0;
         ser_data_oe_o <= 1'b0;
         ser_data_o    <= 1'b1;
         idle_cnt      <= '0;
      end else if (!ser_busy) begin
         ser_data_oe_o <= 1'b1;
         ser_data_o    <= 1'b1;
         if (clk_fall) begin
            shift_reg <= word_out;
            bits_left <= 6'(EEP_TURN_BITS) + 6'(act_revw);
            ser_busy  <= 1'b1;
            idle_cnt  <= '0;
         end
      end else begin
         if (clk_rise && bits_left != 6'h0) begin
            ser_data_o <= shift_reg[31];
            shift_reg  <= {shift_reg[30:0], 1'b0};
            bits_left  <= 6'(bits_left - 6'h1);
         end
         if (clk_rise || clk_fall)
            idle_cnt <= '0;
         else
            idle_cnt <= 16'(idle_cnt + 16'h1);
         // Clock resting high past the timeout ends the frame
         if (clk_s && idle_cnt >= 16'(EEP_MONO_CYC)) begin
            ser_busy   <= 1'b0;
            ser_data_o <= 1'b1;
         end
      end
   end

   // Flag a clock half shorter than the configured rate
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         half_cnt <= '0;
         rate_err <= 1'b0;
         ppt_err  <= 1'b0;
      end else begin
         if (clk_rise || clk_fall)
            half_cnt <= 16'h1; // Edge cycle is the first of the half
         else if (half_cnt != 16'hFFFF)
            half_cnt <= 16'(half_cnt + 16'h1);
         // Set wins over a clear in the same cycle
         if (ser_busy && (clk_rise || clk_fall) &&
             half_cnt < ser_rate_div)
            rate_err <= 1'b1;
         else if (reg_wr_i && reg_addr_i == EEP_REG_STATUS &&
                  reg_wdata_i[EEP_ST_RERR])
            rate_err <= 1'b0;
         if (reg_wr_i && reg_addr_i == EEP_REG_PPT && !ppt_ok)
            ppt_err <= 1'b1;
         else if (reg_wr_i && reg_addr_i == EEP_REG_STATUS &&
                  reg_wdata_i[EEP_ST_PERR])
            ppt_err <= 1'b0;
      end
   end

   // ****************************************************************
   // Read port, data one cycle after the strobe
   // ****************************************************************
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         reg_rdata_o <= '0;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            EEP_REG_FUNC:   reg_rdata_o <= {28'h0, emulation_function_select};
            EEP_REG_PPT:    reg_rdata_o <= {12'h0, pulses_per_turn_setting};
            EEP_REG_OFFS:   reg_rdata_o <= 32'(index_pulse_angle_offset);
            EEP_REG_SERCFG: reg_rdata_o <= {22'h0, dir_invert, gray_sel,
                                            3'h0, revolution_field_width};
            EEP_REG_STATUS: reg_rdata_o <= {29'h0, rate_err, ppt_err,
                                            ser_busy};
            EEP_REG_CLKDIV: reg_rdata_o <= {16'h0, ser_rate_div};
            default:        reg_rdata_o <= '0;
         endcase
      end else begin
         reg_rdata_o <= '0;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   AST_QUAD_GRAY: assert property (@(posedge mclk_i)
      disable iff (!resetn_i) !($changed(quad_a_o) && $changed(quad_b_o)))
      else $error("A and B changed together");
   AST_INDEX_AB: assert property (@(posedge mclk_i)
      disable iff (!resetn_i) index_pulse_o |-> (quad_a_o && quad_b_o))
      else $error("Index outside A=B=1");
   AST_INDEX_MODE: assert property (@(posedge mclk_i)
      disable iff (!resetn_i) (act_func != EEP_FUNC_INCR) |=> !index_pulse_o)
      else $error("Index outside quadrature mode");
   AST_PPT_SAFE: assert property (@(posedge mclk_i)
      disable iff (!resetn_i)
      (reg_wr_i && reg_addr_i == EEP_REG_PPT && safety_fitted_i &&
       reg_wdata_i[19:0] > EEP_PPT_SAFE_MAX)
      |=> $stable(pulses_per_turn_setting))
      else $error("Safety resolution limit broken");
   AST_LEN: assert property (@(posedge mclk_i)
      disable iff (!resetn_i) bits_left <= 6'(EEP_WORD_MAX))
      else $error("Serial word too long");
   AST_LATCH: assert property (@(posedge mclk_i)
      disable iff (!resetn_i)
      (!ser_busy && clk_fall && act_func == EEP_FUNC_SERIAL)
      |=> ser_busy && shift_reg == $past(word_out))
      else $error("Word not latched at first edge");
   AST_HOLD_CFG: assert property (@(posedge mclk_i)
      disable iff (!resetn_i)
      ser_busy |=> $stable(act_revw) && $stable(act_gray))
      else $error("Config changed inside a frame");
   AST_REVW: assert property (@(posedge mclk_i)
      disable iff (!resetn_i) revolution_field_width >= EEP_REVW_MIN &&
      revolution_field_width <= EEP_REVW_MAX)
      else $error("Revolution width out of range");
   AST_IDLE_OFF: assert property (@(posedge mclk_i)
      disable iff (!resetn_i) (act_func != EEP_FUNC_SERIAL) |=> !ser_data_oe_o)
      else $error("Serial driver on in wrong mode");

   COV_INDEX:  cover property (@(posedge mclk_i) index_pulse_o);
   COV_FRAME:  cover property (@(posedge mclk_i) $fell(ser_busy));
   COV_GRAY:   cover property (@(posedge mclk_i) ser_busy && act_gray);
   COV_RATE:   cover property (@(posedge mclk_i) $rose(rate_err));

endmodule

// File: tb/eep_eval_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Evaluator model: clocks the serial position word out
// ****************************************************************
// Acts as the clock master reading the word as a serial absolute source
module eep_eval_model #(
   parameter int HALF_NS = 400 // Half period of the shift clock
) (
   input  wire logic ser_data_i,
   output logic      ser_clk_o
);
   // Clock stands high between frames, never free running
   initial ser_clk_o = 1'b1;

   // Fall opens the frame, each rise moves one bit, MSB first
   task automatic read_word(input int nbits, output logic [31:0] w);
      w = 32'h0;
      // Keep every link edge clear of the system clock edges
      #(HALF_NS / 16);
      ser_clk_o = 1'b0;
      #(HALF_NS);
      for (int i = 0; i < nbits; i++) begin
         ser_clk_o = 1'b1;
         #(HALF_NS);
         w = {w[30:0], ser_data_i};
         // Last rise leaves the clock high to close the frame
         if (i < nbits - 1) begin
            ser_clk_o = 1'b0;
            #(HALF_NS);
         end
      end
      // Idle well past the frame end time before the next read
      #(30000);
   endtask
endmodule

// File: tb/eep_top_tb_top.sv
`timescale 1ns/1ps
// ****************************************************************
// Bench for the encoder position emulation
// ****************************************************************
module eep_top_tb_top;
   import eep_pkg::*;

   localparam int PW = 20; // Angle width handed to the design

   typedef struct packed {
      logic        fb;   // 1 encoder, 0 resolver
      logic        safe; // Safety option fitted
      logic [19:0] v;    // Requested pulses per turn
      logic        ok;   // Setting must be taken
   } eep_ppt_row_t;
   typedef struct packed {
      logic [9:0]  cfg;  // Serial word configuration
      logic [15:0] t;    // Revolution count
      logic [19:0] a;    // Angle in turn
      logic [15:0] div;  // Rate setting, above 4 is too slow for us
   } eep_ser_row_t;

   localparam eep_ppt_row_t PPT_ROWS [11] = '{
      '{1'h0, 1'h0, 20'h00020, 1'h1}, '{1'h0, 1'h0, 20'h0001F, 1'h0},
      '{1'h0, 1'h0, 20'h01000, 1'h1}, '{1'h0, 1'h0, 20'h01001, 1'h0},
      '{1'h1, 1'h0, 20'h00100, 1'h1}, '{1'h1, 1'h0, 20'h000FF, 1'h0},
      '{1'h1, 1'h0, 20'h80000, 1'h1}, '{1'h1, 1'h0, 20'h80001, 1'h0},
      '{1'h1, 1'h1, 20'h00800, 1'h1}, '{1'h1, 1'h1, 20'h00600, 1'h0},
      '{1'h1, 1'h1, 20'h02000, 1'h0}};
   localparam eep_ser_row_t SER_ROWS [4] = '{
      '{10'h00C, 16'hFABC, 20'h12345, 16'h0003},
      '{10'h110, 16'hABCD, 20'hFEDCB, 16'h0003},
      '{10'h214, 16'h8001, 20'h0000F, 16'h0004},
      '{10'h10E, 16'h3FFF, 20'h80000, 16'h0006}};

   logic          mclk   = 1'b0;  // 10 MHz system clock
   logic          rst_n  = 1'b0;  // Active-low reset
   logic [3:0]    addr   = 4'h0;  // Register index
   logic [31:0]   wdata  = 32'h0; // Write data
   logic          wr     = 1'b0;  // Write strobe
   logic          rd     = 1'b0;  // Read strobe
   logic [31:0]   rdata;          // Read data
   logic [PW-1:0] angle  = '0;    // Shaft angle in turn
   logic [15:0]   turns  = 16'h0; // Revolution count
   logic          fb     = 1'b0;  // Feedback type
   logic          safe   = 1'b0;  // Safety option
   logic          ser_clk, ser_data, ser_oe, qa, qb, idx;
   logic [1:0]    qs_prev  = 2'h0; // Last decoded quadrature state
   logic          idx_prev = 1'b0; // Index level last cycle
   logic [31:0]   got;             // Scratch for reads
   logic [31:0]   st;              // Status read inside a frame
   logic [19:0]   ppt_exp  = EEP_PPT_RESET; // Expected resolution
   int            error_cnt = 0, cmp_count = 0;
   int            qcnt = 0, idx_n = 0, idx_at = 0, q0, i0, n;

   eep_top #(.PW(PW)) u_dut (
      .mclk_i(mclk), .resetn_i(rst_n), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_rdata_o(rdata), .shaft_angle_i(angle), .shaft_turns_i(turns),
      .feedback_source_type_i(fb), .safety_fitted_i(safe),
      .ser_clk_i(ser_clk), .ser_data_o(ser_data), .ser_data_oe_o(ser_oe),
      .quad_a_o(qa), .quad_b_o(qb), .index_pulse_o(idx));
   eep_eval_model u_eval (.ser_data_i(ser_data), .ser_clk_o(ser_clk));

   always #50 mclk = ~mclk;

   // ****************************************************************
   // Checks and bus tasks
   // ****************************************************************
   task automatic chk(input string nm, input logic [31:0] e, g);
      cmp_count++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   // Data stand only in the cycle after the strobe: sample mid-cycle
   task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      @(negedge mclk);
      d = rdata;
   endtask
   task automatic rd_chk(input string nm, input logic [3:0] a,
                         input logic [31:0] e);
      logic [31:0] d;
      rd_reg(a, d);
      chk(nm, e, d);
   endtask
   task automatic end_of_test();
      $display("errors %0d compares %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Serial word as the evaluator should see it, right aligned
   function automatic int rev_w(input logic [4:0] f);
      return (f > 5'h10) ? 16 : ((f < 5'h0C) ? 12 : int'(f));
   endfunction
   function automatic logic [31:0] exp_word(input logic [9:0] c,
      input logic [15:0] t, input logic [19:0] a);
      logic [31:0] b;
      b = ({16'h0, t} & ((32'h1 << rev_w(c[4:0])) - 32'h1)) << 16;
      b = b | {16'h0, c[9] ? ~a[19:4] : a[19:4]};
      return c[8] ? (b ^ (b >> 1)) : b;
   endfunction

   // Quadrature decoder: state {B, A^B} steps by one per edge
   always @(posedge mclk) begin
      if (2'({qb, qa ^ qb} - qs_prev) == 2'h1) qcnt++;
      else if (2'({qb, qa ^ qb} - qs_prev) == 2'h3) qcnt--;
      else if ({qb, qa ^ qb} != qs_prev) chk("quad_step", 0, 1);
      if (idx === 1'b1) begin
         chk("index_ab", 2'h3, {qa, qb});
         if (!idx_prev) idx_n++;
         if (!idx_prev) idx_at = qcnt;
      end
      qs_prev = {qb, qa ^ qb};
      idx_prev = idx;
   end

   // Whole run is well under 2 ms, so 5 ms means a hang
   initial begin
      #(5000000);
      error_cnt++;
      end_of_test();
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      chk("idle_out", 5'h02, {qa, qb, idx, ser_data, ser_oe});
      rd_chk("func", EEP_REG_FUNC, 32'h0);
      rd_chk("ppt", EEP_REG_PPT, {12'h0, EEP_PPT_RESET});
      rd_chk("sercfg", EEP_REG_SERCFG, {27'h0, EEP_REVW_RESET});
      rd_chk("clkdiv", EEP_REG_CLKDIV, {16'h0, EEP_CLKDIV_RESET});
      rd_chk("unmapped", 4'hF, 32'h0);
      // Resolution table: refused values keep the last setting
      foreach (PPT_ROWS[i]) begin
         @(posedge mclk);
         fb <= PPT_ROWS[i].fb;
         safe <= PPT_ROWS[i].safe;
         wr_reg(EEP_REG_STATUS, 32'h2);
         wr_reg(EEP_REG_PPT, {12'h0, PPT_ROWS[i].v});
         if (PPT_ROWS[i].ok) ppt_exp = PPT_ROWS[i].v;
         rd_chk("ppt", EEP_REG_PPT, {12'h0, ppt_exp});
         rd_reg(EEP_REG_STATUS, got);
         chk("ppt_rej", !PPT_ROWS[i].ok, got[EEP_ST_PERR]);
      end
      // Serial frames, inputs and coding changed mid-frame
      wr_reg(EEP_REG_FUNC, {28'h0, EEP_FUNC_SERIAL});
      foreach (SER_ROWS[i]) begin
         n = rev_w(SER_ROWS[i].cfg[4:0]) + 16;
         wr_reg(EEP_REG_SERCFG, {22'h0, SER_ROWS[i].cfg});
         wr_reg(EEP_REG_CLKDIV, {16'h0, SER_ROWS[i].div});
         wr_reg(EEP_REG_STATUS, 32'h6);
         turns <= SER_ROWS[i].t;
         angle <= SER_ROWS[i].a;
         repeat (4) @(posedge mclk);
         fork
            u_eval.read_word(n, got);
            begin
               repeat (60) @(posedge mclk);
               angle <= ~SER_ROWS[i].a;
               turns <= ~SER_ROWS[i].t;
               wr_reg(EEP_REG_SERCFG, {22'h0, SER_ROWS[i].cfg ^ 10'h100});
               rd_reg(EEP_REG_STATUS, st);
               chk("ser_busy", 1, st[EEP_ST_BUSY]);
            end
         join
         chk("ser_word", exp_word(SER_ROWS[i].cfg, SER_ROWS[i].t,
             SER_ROWS[i].a), got);
         chk("ser_idle", 2'h3, {ser_oe, ser_data});
         rd_reg(EEP_REG_STATUS, got);
         chk("rate_err", SER_ROWS[i].div > 4, got[EEP_ST_RERR]);
      end
      // Quadrature: half a turn forward and back, then forward with a new setting
      wr_reg(EEP_REG_FUNC, {28'h0, EEP_FUNC_OFF});
      fb <= 1'b1;
      wr_reg(EEP_REG_PPT, 32'h100);
      wr_reg(EEP_REG_OFFS, 32'h40000);
      angle <= '0;
      wr_reg(EEP_REG_FUNC, {28'h0, EEP_FUNC_INCR});
      repeat (5000) @(posedge mclk);
      q0 = qcnt;
      i0 = idx_n;
      // Just short of half a turn, so the shortest way is forward
      angle <= 20'h7F000;
      repeat (700) @(posedge mclk);
      chk("quad_count", 508, qcnt - q0);
      chk("index_n", 1, idx_n - i0);
      chk("index_at", 1, idx_at - q0 >= 252 && idx_at - q0 <= 260);
      angle <= '0;
      repeat (600) @(posedge mclk);
      chk("quad_back", q0, qcnt);
      // Double resolution: three quarters of a turn gain 3 * 256 edges
      wr_reg(EEP_REG_PPT, 32'h200);
      repeat (1200) @(posedge mclk);
      chk("quad_rescale", q0 + 768, qcnt);
      // Reset in mid-run: outputs idle at once, settings back to reset
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      chk("rst_out", 5'h02, {qa, qb, idx, ser_data, ser_oe});
      rst_n <= 1'b1;
      rd_chk("rst_func", EEP_REG_FUNC, 32'h0);
      rd_chk("rst_ppt", EEP_REG_PPT, {12'h0, EEP_PPT_RESET});
      end_of_test();
   end
endmodule
